/* logic/smr_pkg.sv */
// shared constants for the sync monitor, phase ramp and interrupt pin configuration
package smr_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] SYNC_MON_CFG_ADDR  = 8'h7c;
    localparam logic [7:0] IRQ_OUT_CFG_ADDR   = 8'h7d;
    localparam logic [7:0] SYNC_MON_CFG_RESET = 8'h2b;
    localparam logic [7:0] IRQ_OUT_CFG_RESET  = 8'h02;
    localparam logic [7:0] IRQ_OUT_CFG_MASK   = 8'h07;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CAL_SELECT_BIT   = 7;
    localparam int MON_LIMIT_LSB    = 4;
    localparam int MON_LIMIT_W      = 3;
    localparam int IRQ_GPO_BIT      = 2;
    localparam int IRQ_FLOAT_BIT    = 1;
    localparam int IRQ_POLARITY_BIT = 0;

    // ------------------------------------------------------------------
    // phase offset and ramp
    // ------------------------------------------------------------------
    localparam int          PHASE_W    = 16;
    localparam logic [15:0] RAMP_STEP  = 16'h0001;
    localparam logic [15:0] PHASE_ZERO = 16'h0000;

    // ------------------------------------------------------------------
    // monitor counter width, enough for 8 ui plus saturation
    // ------------------------------------------------------------------
    localparam int          UI_CNT_W   = 4;
    localparam logic [3:0]  UI_CNT_MAX = 4'hf;

    typedef enum logic [2:0] {
        RMP_IDLE    = 3'b000,
        RMP_TRACK   = 3'b001,
        RMP_TO_ZERO = 3'b010,
        RMP_DIV_RST = 3'b011,
        RMP_BACK    = 3'b100
    } smr_ramp_state_t;

endpackage

/* logic/smr_phase_ramp.sv */
// phase offset ramp engine with the calibration sequence
`timescale 1ns/100ps
module smr_phase_ramp
    import smr_pkg::*;
#(
    parameter int W = PHASE_W
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // control
    input  wire logic [W-1:0] target,
    input  wire logic         cal_start,
    // status
    output logic [W-1:0]      applied_ff,
    output logic              holdover_ff,
    output logic              div_reset_ff,
    output logic              busy_ff
);

    smr_ramp_state_t state_ff;
    smr_ramp_state_t nxt_state;
    logic [W-1:0]    latched_ff;
    logic [W-1:0]    goal;
    logic [W-1:0]    nxt_applied;
    logic [W-1:0]    step_w;
    logic            at_goal;
    logic            goal_above;

    assign step_w = RAMP_STEP[W-1:0];

    // ------------------------------------------------------------------
    // goal select: updates are frozen while calibrating
    // ------------------------------------------------------------------
    assign goal = (state_ff == RMP_TO_ZERO || state_ff == RMP_DIV_RST) ? PHASE_ZERO[W-1:0] :
                  (state_ff == RMP_BACK) ? latched_ff : target;
    assign at_goal    = (applied_ff == goal);
    assign goal_above = ($signed(goal) > $signed(applied_ff));
    // one step a clock keeps the output phase free of visible jumps
    assign nxt_applied = at_goal ? applied_ff :
                         goal_above ? applied_ff + step_w : applied_ff - step_w;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            RMP_IDLE:
            begin
                if (cal_start)
                    nxt_state = RMP_TO_ZERO;
                else if (!at_goal)
                    nxt_state = RMP_TRACK;
            end
            RMP_TRACK:
            begin
                if (cal_start)
                    nxt_state = RMP_TO_ZERO;
                else if (nxt_applied == goal)
                    nxt_state = RMP_IDLE;
            end
            RMP_TO_ZERO:
            begin
                if (nxt_applied == goal)
                    nxt_state = RMP_DIV_RST;
            end
            RMP_DIV_RST: nxt_state = RMP_BACK;
            RMP_BACK:
            begin
                if (nxt_applied == goal)
                    nxt_state = RMP_IDLE;
            end
            default: nxt_state = RMP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff     <= RMP_IDLE;
            applied_ff   <= '0;
            latched_ff   <= '0;
            holdover_ff  <= 1'b0;
            div_reset_ff <= 1'b0;
            busy_ff      <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            applied_ff   <= (state_ff == RMP_DIV_RST) ? applied_ff : nxt_applied;
            if (cal_start && (state_ff == RMP_IDLE || state_ff == RMP_TRACK))
                latched_ff <= target;
            holdover_ff  <= (nxt_state == RMP_TO_ZERO || nxt_state == RMP_DIV_RST ||
                             nxt_state == RMP_BACK);
            div_reset_ff <= (nxt_state == RMP_DIV_RST);
            busy_ff      <= (nxt_state != RMP_IDLE);
        end
    end

endmodule

/* logic/smr_sync_monitor.sv */
// sync monitor, phase ramp control and interrupt pin configuration registers
// Overview of operation
// - with calibrate bit clear, offset changes ramp gradually from old to new value
// - calibrate bit: holdover, ramp to zero, reset dividers, ramp back, leave holdover
// - external sync is only monitored against generated output alignment
// - sync alarm flag set when sync edge misses the alignment window
// - window field codes 000..111 mean plus or minus 1..8 equipment clock ui
// - float clear: pin always driven; float set: driven only while interrupt active or gpo bit set
`timescale 1ns/100ps
module smr_sync_monitor
    import smr_pkg::*;
#(
    parameter int PW = PHASE_W
)
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // register access port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [7:0]         reg_rdata_ff,
    // phase offset from the offset registers
    input  wire logic [PW-1:0] phase_offset_target,
    // alignment events
    input  wire logic          ui_tick,
    input  wire logic          out_frame_edge,
    input  wire logic          ext_sync_edge,
    output logic               sync_alarm_set_ff,
    // phase ramp status
    output logic [PW-1:0]      applied_phase_offset_ff,
    output logic               holdover_ff,
    output logic               divider_reset_ff,
    output logic               calibrating_ff,
    // interrupt pin
    input  wire logic          irq_active,
    output logic               irq_pin_o_ff,
    output logic               irq_pin_oe_ff
);

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic [7:0] sync_monitor_config_ff;
    logic [7:0] irq_output_config_ff;
    logic       wr_sync_cfg;
    logic       wr_irq_cfg;
    logic       cal_launch;
    logic [7:0] rd_mux;

    assign wr_sync_cfg = reg_wr && (reg_addr == SYNC_MON_CFG_ADDR);
    assign wr_irq_cfg  = reg_wr && (reg_addr == IRQ_OUT_CFG_ADDR);
    // a write of one launches once; a second write during the sequence is ignored
    assign cal_launch  = wr_sync_cfg && reg_wdata[CAL_SELECT_BIT] &&
                         !sync_monitor_config_ff[CAL_SELECT_BIT];
    // any other address reads as zero
    assign rd_mux = (reg_addr == SYNC_MON_CFG_ADDR) ? sync_monitor_config_ff :
                    (reg_addr == IRQ_OUT_CFG_ADDR)  ? irq_output_config_ff : 8'h00;

    // ------------------------------------------------------------------
    // phase ramp engine
    // ------------------------------------------------------------------
    logic [PW-1:0] ramp_applied;
    logic          ramp_holdover;
    logic          ramp_div_reset;
    logic          ramp_busy;
    logic          ramp_busy_q_ff;
    logic          cal_done;

    smr_phase_ramp #(
        .W (PW)
    ) u_ramp (
        .clk          (clk),
        .resetn       (resetn),
        .target       (phase_offset_target),
        .cal_start    (cal_launch),
        .applied_ff   (ramp_applied),
        .holdover_ff  (ramp_holdover),
        .div_reset_ff (ramp_div_reset),
        .busy_ff      (ramp_busy)
    );

    // calibration ends when the engine leaves holdover
    assign cal_done = sync_monitor_config_ff[CAL_SELECT_BIT] && ramp_busy_q_ff && !ramp_busy;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_monitor_config_ff <= SYNC_MON_CFG_RESET;
            irq_output_config_ff   <= IRQ_OUT_CFG_RESET;
            reg_rdata_ff           <= 8'h00;
            ramp_busy_q_ff         <= 1'b0;
        end
        else
        begin
            ramp_busy_q_ff <= ramp_busy;
            if (wr_sync_cfg)
            begin
                sync_monitor_config_ff[6:0] <= reg_wdata[6:0];
                if (!sync_monitor_config_ff[CAL_SELECT_BIT])
                    sync_monitor_config_ff[CAL_SELECT_BIT] <= reg_wdata[CAL_SELECT_BIT];
            end
            if (cal_done)
                sync_monitor_config_ff[CAL_SELECT_BIT] <= 1'b0;
            if (wr_irq_cfg)
                irq_output_config_ff <= reg_wdata & IRQ_OUT_CFG_MASK;
            if (reg_rd)
                reg_rdata_ff <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // sync alignment monitor
    // ------------------------------------------------------------------
    logic [UI_CNT_W-1:0] limit_ui;
    logic [UI_CNT_W-1:0] since_sync_ff;
    logic [UI_CNT_W-1:0] since_out_ff;
    logic                waiting_ff;
    logic                sync_recent;
    logic                window_expired;
    logic                alarm_now;

    // code 000 means 1 ui, so add one
    assign limit_ui = {1'b0, sync_monitor_config_ff[MON_LIMIT_LSB +: MON_LIMIT_W]} +
                      {{(UI_CNT_W-1){1'b0}}, 1'b1};
    // early sync: seen no more than the limit before the output edge
    assign sync_recent    = ext_sync_edge || (since_sync_ff <= limit_ui);
    // late sync: the window after the output edge ran out
    assign window_expired = waiting_ff && ui_tick && (since_out_ff >= limit_ui);
    assign alarm_now      = (out_frame_edge && !sync_recent && waiting_ff) ||
                            (window_expired && !ext_sync_edge);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            since_sync_ff     <= UI_CNT_MAX;
            since_out_ff      <= 4'h0;
            waiting_ff        <= 1'b0;
            sync_alarm_set_ff <= 1'b0;
        end
        else
        begin
            // saturates so a long quiet gap never wraps back into the window
            if (ext_sync_edge)
                since_sync_ff <= 4'h0;
            else if (ui_tick && since_sync_ff != UI_CNT_MAX)
                since_sync_ff <= since_sync_ff + 4'h1;
            if (out_frame_edge)
            begin
                since_out_ff <= 4'h0;
                waiting_ff   <= !sync_recent;
            end
            else
            begin
                if (ui_tick && since_out_ff != UI_CNT_MAX)
                    since_out_ff <= since_out_ff + 4'h1;
                if (ext_sync_edge || window_expired)
                    waiting_ff <= 1'b0;
            end
            sync_alarm_set_ff <= alarm_now;
        end
    end

    // ------------------------------------------------------------------
    // interrupt pin drive
    // ------------------------------------------------------------------
    logic irq_pol;
    logic irq_gpo;
    logic irq_float;
    logic nxt_irq_o;
    logic nxt_irq_oe;

    assign irq_pol    = irq_output_config_ff[IRQ_POLARITY_BIT];
    assign irq_gpo    = irq_output_config_ff[IRQ_GPO_BIT];
    assign irq_float  = irq_output_config_ff[IRQ_FLOAT_BIT];
    // as general output the pin simply carries the polarity bit
    assign nxt_irq_o  = irq_gpo ? irq_pol : (irq_active ? irq_pol : !irq_pol);
    assign nxt_irq_oe = irq_gpo || !irq_float || irq_active;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // float is set out of reset, so the pin stays released while idle
            irq_pin_o_ff  <= 1'b1;
            irq_pin_oe_ff <= 1'b0;
        end
        else
        begin
            irq_pin_o_ff  <= nxt_irq_o;
            irq_pin_oe_ff <= nxt_irq_oe;
        end
    end

    // ------------------------------------------------------------------
    // phase ramp status outputs
    // ------------------------------------------------------------------
    // registered once more so every status output leaves a flip-flop
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            applied_phase_offset_ff <= '0;
            holdover_ff             <= 1'b0;
            divider_reset_ff        <= 1'b0;
            calibrating_ff          <= 1'b0;
        end
        else
        begin
            applied_phase_offset_ff <= ramp_applied;
            holdover_ff             <= ramp_holdover;
            divider_reset_ff        <= ramp_div_reset;
            // mirrors the calibrate bit one clock late
            calibrating_ff          <= sync_monitor_config_ff[CAL_SELECT_BIT];
        end
    end

endmodule

/* verification/smr_sync_monitor_checker.sv */
// concurrent checks on the ports of the sync monitor block
`timescale 1ns/100ps
module smr_sync_monitor_checker
    import smr_pkg::*;
#(
    parameter int PW = PHASE_W
)
(
    // clock and reset
    input wire logic          clk,
    input wire logic          resetn,
    // register access port
    input wire logic [7:0]    reg_addr,
    input wire logic [7:0]    reg_wdata,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [7:0]    reg_rdata_ff,
    // alignment events
    input wire logic          ui_tick,
    input wire logic          out_frame_edge,
    input wire logic          sync_alarm_set_ff,
    // ramp status
    input wire logic [PW-1:0] applied_phase_offset_ff,
    input wire logic          holdover_ff,
    input wire logic          divider_reset_ff,
    input wire logic          calibrating_ff,
    // interrupt pin
    input wire logic          irq_active,
    input wire logic          irq_pin_oe_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_cal_write;
        reg_wr && reg_addr == SYNC_MON_CFG_ADDR && reg_wdata[CAL_SELECT_BIT];
    endsequence

    // a write while the bit is already set still sees the first launch in flight, unless it lands as the engine leaves holdover or one cycle later
    chk_cal_start: assert property (s_cal_write |-> ##2 (holdover_ff && calibrating_ff))
        else $error("calibration did not enter holdover");
    chk_div_in_hold: assert property (divider_reset_ff |->
        holdover_ff && calibrating_ff)
        else $error("divider reset outside calibration");
    chk_div_pulse: assert property (divider_reset_ff |=> !divider_reset_ff)
        else $error("divider reset longer than one cycle");
    chk_ramp_step: assert property (!$stable(applied_phase_offset_ff) |->
        (applied_phase_offset_ff == $past(applied_phase_offset_ff) + 16'h0001 ||
         applied_phase_offset_ff == $past(applied_phase_offset_ff) - 16'h0001))
        else $error("applied offset jumped");
    chk_alarm_cause: assert property (sync_alarm_set_ff |->
        $past(out_frame_edge || ui_tick))
        else $error("alarm without a deciding event");
    chk_cal_end: assert property ($fell(calibrating_ff) |-> !holdover_ff)
        else $error("calibration ended inside holdover");
    chk_irq_oe_active: assert property (irq_active |=> irq_pin_oe_ff)
        else $error("interrupt pin not driven while active");
    chk_unmapped_rd: assert property (reg_rd && reg_addr != SYNC_MON_CFG_ADDR &&
        reg_addr != IRQ_OUT_CFG_ADDR |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    chk_irq_spare_rd: assert property (reg_rd && reg_addr == IRQ_OUT_CFG_ADDR |=>
        reg_rdata_ff[7:3] == 5'h00)
        else $error("unused interrupt config bits read set");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data changed without a read");
endmodule

bind smr_sync_monitor smr_sync_monitor_checker #(.PW(PW)) u_chk (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .ui_tick(ui_tick),
    .out_frame_edge(out_frame_edge), .sync_alarm_set_ff(sync_alarm_set_ff),
    .applied_phase_offset_ff(applied_phase_offset_ff), .holdover_ff(holdover_ff),
    .divider_reset_ff(divider_reset_ff), .calibrating_ff(calibrating_ff),
    .irq_active(irq_active), .irq_pin_oe_ff(irq_pin_oe_ff));

/* verification/smr_sync_card.sv */
// model of the clock card that sends ui ticks and the external sync edge
`timescale 1ns/100ps
module smr_sync_card
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // request
    input  wire logic       start,
    input  wire logic [3:0] ticks,
    input  wire logic       send_sync,
    // events
    output logic            ui_tick,
    output logic            ext_sync_edge,
    output logic            busy
);
    logic [3:0] left_ff;
    logic [1:0] ph_ff;
    logic       pend_ff;

    // one ui is four system clocks; sync follows the last tick by one ui
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {left_ff, ph_ff, pend_ff, ui_tick, ext_sync_edge, busy} <= '0;
        end
        else
        begin
            ui_tick       <= 1'b0;
            ext_sync_edge <= 1'b0;
            if (start)
            begin
                {left_ff, ph_ff, pend_ff, busy} <= {ticks, 2'h0, send_sync, 1'b1};
            end
            else if (busy)
            begin
                ph_ff <= ph_ff + 2'h1;
                if (ph_ff == 2'h3 && left_ff != 4'h0)
                begin
                    ui_tick <= 1'b1;
                    left_ff <= left_ff - 4'h1;
                end
                if (ph_ff == 2'h3 && left_ff == 4'h0)
                begin
                    ext_sync_edge <= pend_ff;
                    busy          <= 1'b0;
                end
            end
        end
    end
endmodule

/* verification/tb_smr_sync_monitor.sv */
// self-checking bench for the sync monitor and ramp configuration block
`timescale 1ns/100ps
module tb_smr_sync_monitor;
    import smr_pkg::*;
    logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, out_frame_edge = 0, irq_active = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff, rd_v;
    logic [15:0] target = 16'h0000, applied;
    logic ui_tick, ext_sync_edge, alarm, hold, divr, calib, pin_o, pin_oe, start = 0, send = 0;
    logic [3:0] ticks = 4'h0;
    logic busy;
    int fail_count = 0, total_checks = 0, alarm_cnt = 0, div_cnt = 0, cyc = 0;

    smr_sync_monitor u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .phase_offset_target(target), .ui_tick(ui_tick), .out_frame_edge(out_frame_edge),
        .ext_sync_edge(ext_sync_edge), .sync_alarm_set_ff(alarm),
        .applied_phase_offset_ff(applied), .holdover_ff(hold), .divider_reset_ff(divr),
        .calibrating_ff(calib), .irq_active(irq_active), .irq_pin_o_ff(pin_o),
        .irq_pin_oe_ff(pin_oe));
    smr_sync_card u_card (.clk(clk), .resetn(resetn), .start(start), .ticks(ticks),
        .send_sync(send), .ui_tick(ui_tick), .ext_sync_edge(ext_sync_edge), .busy(busy));

    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (alarm === 1'b1) alarm_cnt++;
        if (divr === 1'b1) div_cnt++;
        // ceiling well above the roughly 1300 cycles the tests need
        if (cyc == 20000)
        begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk);
        reg_rd = 1'b0;
        rd_v = reg_rdata_ff;
    endtask

    task automatic ramp_to(input logic [15:0] v);
        target = v;
        for (int k = 0; k < 300 && applied !== v; k++) @(negedge clk);
        chk("applied", v, applied);
    endtask

    initial
    begin
        repeat (2) @(negedge clk);
        resetn = 1;
        rd(SYNC_MON_CFG_ADDR);
        chk("mon_cfg", 16'h002b, {8'h00, rd_v});
        rd(IRQ_OUT_CFG_ADDR);
        chk("irq_cfg", 16'h0002, {8'h00, rd_v});
        rd(8'h7b);
        chk("unmapped", 16'h0000, {8'h00, rd_v});
        wr(IRQ_OUT_CFG_ADDR, 8'hff);
        rd(IRQ_OUT_CFG_ADDR);
        chk("irq_spare", 16'h0007, {8'h00, rd_v});
        // gpo, float and polarity against both interrupt levels
        for (int i = 0; i < 16; i++)
        begin
            wr(IRQ_OUT_CFG_ADDR, {5'h00, i[2:0]});
            irq_active = i[3];
            repeat (2) @(negedge clk);
            chk("irq_pin", {14'h0, i[2] ? i[0] : (i[3] ? i[0] : !i[0]),
                i[2] | !i[1] | i[3]}, {14'h0, pin_o, pin_oe});
        end
        $display("test irq pin done");
        ramp_to(16'h0005);
        ramp_to(16'hfffe);
        ramp_to(16'h0005);
        $display("test ramp done");
        wr(SYNC_MON_CFG_ADDR, 8'hab);
        for (int k = 0; k < 20 && hold !== 1'b1; k++) @(negedge clk);
        chk("holdover", 16'h0001, {15'h0, hold});
        chk("calibrating", 16'h0001, {15'h0, calib});
        // a newer target must wait until the sequence has finished
        target = 16'h0003;
        for (int k = 0; k < 300 && hold === 1'b1; k++) @(negedge clk);
        chk("div_reset", 16'h0001, div_cnt[15:0]);
        chk("ramp_back", 16'h0005, applied);
        ramp_to(16'h0003);
        repeat (2) @(negedge clk);
        rd(SYNC_MON_CFG_ADDR);
        chk("cal_clear", 16'h002b, {8'h00, rd_v});
        chk("cal_level", 16'h0000, {15'h0, calib});
        $display("test calibration done");
        for (int c = 0; c < 8; c++)
        begin
            wr(SYNC_MON_CFG_ADDR, {1'b0, c[2:0], 4'hb});
            rd(SYNC_MON_CFG_ADDR);
            chk("limit", {8'h0, 1'b0, c[2:0], 4'hb}, {8'h0, rd_v});
            for (int s = 0; s < 2; s++)
            begin
                automatic int base = alarm_cnt;
                // age the last sync beyond every window before the next output edge
                @(negedge clk);
                {start, send, ticks} = {2'b10, 4'ha};
                @(negedge clk);
                start = 1'b0;
                for (int k = 0; k < 100 && busy === 1'b1; k++) @(negedge clk);
                @(negedge clk);
                {out_frame_edge, start, send, ticks} = {2'b11, s[0], 4'(c + 2 - s)};
                @(negedge clk);
                {out_frame_edge, start} = 2'b00;
                for (int k = 0; k < 100 && busy === 1'b1; k++) @(negedge clk);
                repeat (3) @(negedge clk);
                chk("alarm", {15'h0, !s[0]}, 16'(alarm_cnt - base));
            end
        end
        $display("test sync monitor done");
        stop_test();
    end
endmodule
